/* File: src/pqc_pkg.sv */
package pqc_pkg;

   // ****************************************
   // Bus geometry
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ****************************************
   // Register offsets
   // ****************************************
   localparam logic [ADDR_W-1:0] OFS_CAP_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_FWD_VEC = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PORT_CTRL = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_COMN_CTRL2 = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_BCAST_LO = 8'h18;
   localparam logic [ADDR_W-1:0] OFS_BCAST_HI = 8'h1C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h24;

   // ****************************************
   // Field positions
   // ****************************************
   localparam int ACK_BIT = 3;
   localparam int HWCAP_BIT = 4;
   localparam int FWD_BIT = 5;
   localparam int LINK_LSB = 7;
   localparam int LINK_W = 6;
   localparam int QREQ_BIT = 0;
   localparam int TSCALE_LSB = 0;
   localparam int TSCALE_W = 2;
   localparam int TVALUE_LSB = 4;
   localparam int TVALUE_W = 8;
   localparam int FWD_VEC_W = 16;
   localparam int MAX_LINKS = 64;

   // ****************************************
   // Events
   // ****************************************
   localparam int EV_ACK_SET = 0;
   localparam int EV_ACK_CLR = 1;
   localparam int EV_TIMEOUT = 2;
   localparam int EV_W = 3;

   // ****************************************
   // Reset values
   // ****************************************
   localparam logic [TSCALE_W-1:0] TSCALE_RST = 2'h0;
   localparam logic [TVALUE_W-1:0] TVALUE_RST = 8'h01;
   localparam logic [EV_W-1:0] IRQ_MASK_RST = 3'h0;

   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIME_UNIT_NS = 1000;
   localparam int TICK_CYCLES = (TIME_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int TICK_W = 4;
   localparam int CNT_W = 18;
   localparam int SCALE_SHIFT = 3;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_QUIET = 2'b01,
      ST_ACKED = 2'b10
   } pqc_state_t;

endpackage : pqc_pkg

/* File: src/pqc_tick_gen.sv */
`timescale 1ns/1ps
module pqc_tick_gen #(
   parameter int PERIOD = pqc_pkg::TICK_CYCLES
) (
   input wire logic clk,
   input wire logic rst_b,
   output logic tick
);
   import pqc_pkg::*;

   typedef struct packed {
      logic [TICK_W-1:0] cnt;
      logic tick;
   } pqc_tick_state_t;

   pqc_tick_state_t cur_ff;
   pqc_tick_state_t nxt_cur;

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.tick = 1'b0;
      if (cur_ff.cnt == TICK_W'(PERIOD - 1)) begin
         nxt_cur.cnt = '0;
         nxt_cur.tick = 1'b1;
      end else begin
         nxt_cur.cnt = cur_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign tick = cur_ff.tick;

endmodule : pqc_tick_gen

/* File: src/pqc_interval_timer.sv */
`timescale 1ns/1ps
module pqc_interval_timer #(
   parameter int WIDTH = pqc_pkg::CNT_W
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic run,
   input wire logic tick,
   input wire logic [WIDTH-1:0] limit,
   output logic done
);
   import pqc_pkg::*;

   typedef struct packed {
      logic [WIDTH-1:0] cnt;
   } pqc_timer_state_t;

   pqc_timer_state_t cur_ff;
   pqc_timer_state_t nxt_cur;

   // Saturates at the limit, so a long wait never wraps back to zero
   always_comb begin
      nxt_cur = cur_ff;
      if (!run) begin
         nxt_cur.cnt = '0;
      end else if (tick && (cur_ff.cnt < limit)) begin
         nxt_cur.cnt = cur_ff.cnt + 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cur_ff <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign done = run && (cur_ff.cnt >= limit);

endmodule : pqc_interval_timer

/* File: src/pqc_port_status.sv */
// What this block does
// - Acknowledge bit reads 0 when not quiesced, 1 once quiesced.
// - With hardware capability, acknowledge is set by the hardware quiesced input.
// - Without capability, first detect the request bit set before acknowledging.
// - Without capability, acknowledge after one full idle quiesce interval.
// - Quiesce interval comes from programmed time scale and value fields.
// - Acknowledge must come within twice the interval after request rise; here a later ack only raises the timeout event.
// - Device can return acknowledge from 1 to 0.
// - Hardware capability bit reads 1 only with a hardware quiesce mechanism.
// - Forwarding capability 1 only if all packets forward; vector then exists.
// - Forwarding capability 1 implements a broadcast forward control vector.
// - Forwarding port passes every packet type in both directions.
// - Broadcast forward control vector exists for every link of the port.
// - Link count field encodes 1 to 63 links; zero never reported.
// - Link count equals the number of link attribute and map entries.
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/1ps
module pqc_port_status
   import pqc_pkg::*;
#(
   parameter bit HW_QACK_CAP = 1'b0,
   parameter bit FWD_CAP = 1'b0,
   parameter int LINK_COUNT = 1,
   parameter logic [15:0] FWD_VECTOR = 16'h0000
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic [pqc_pkg::ADDR_W-1:0] ADDR,
   input wire logic [pqc_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [pqc_pkg::DATA_W-1:0] RDATA,
   input wire logic PORT_IDLE,
   input wire logic HW_QUIESCED,
   output logic PORT_QUIESCE_REQUEST,
   output logic PORT_QUIESCE_ACK,
   output logic [pqc_pkg::MAX_LINKS-1:0] BCAST_FWD_VECTOR,
   output logic IRQ
);
   import pqc_pkg::*;

   // ****************************************
   // Static capability fields
   // ****************************************
   // Zero is reserved, so a count below one is forced up to one link; above 63 it is held at 63
   localparam logic [LINK_W-1:0] LINK_FIELD =
      (LINK_COUNT < 1) ? 6'h01 : (LINK_COUNT > 63) ? 6'h3F : LINK_W'(LINK_COUNT);

   logic [MAX_LINKS-1:0] link_present;

   genvar gi;
   generate
      for (gi = 0; gi < MAX_LINKS; gi++) begin : g_link
         // One vector bit per implemented link, only when forwarding exists
         assign link_present[gi] = FWD_CAP && (gi < int'(LINK_FIELD));
      end
   endgenerate

   // ****************************************
   // State
   // ****************************************
   typedef struct packed {
      pqc_state_t state;
      logic qreq;
      logic [TSCALE_W-1:0] scale;
      logic [TVALUE_W-1:0] tvalue;
      logic [MAX_LINKS-1:0] bcast;
      logic [TICK_W-1:0] phase;
      logic timeout_seen;
      logic [EV_W-1:0] irq_stat;
      logic [EV_W-1:0] irq_mask;
      logic [DATA_W-1:0] rdata;
   } pqc_top_state_t;

   pqc_top_state_t cur_ff;
   pqc_top_state_t nxt_cur;

   logic tick;
   logic quiet_run;
   logic quiet_tick;
   logic total_run;
   logic quiet_done;
   logic total_done;
   logic [CNT_W-1:0] interval;
   logic [CNT_W-1:0] quiet_limit;
   logic [CNT_W-1:0] total_limit;
   logic [EV_W-1:0] events;
   logic [DATA_W-1:0] cap_word;

   // ****************************************
   // Quiesce interval
   // ****************************************
   always_comb begin
      interval = CNT_W'(cur_ff.tvalue) << (SCALE_SHIFT * cur_ff.scale);
      // Own phase starts with the idle run, so the count is exact, never a tick short
      quiet_limit = interval;
      total_limit = CNT_W'({interval, 1'b0});
   end

   assign quiet_run = (cur_ff.state == ST_QUIET) && PORT_IDLE && !HW_QACK_CAP;
   assign total_run = (cur_ff.state == ST_QUIET);
   assign quiet_tick = quiet_run && (cur_ff.phase == TICK_W'(TICK_CYCLES - 1));

   pqc_tick_gen #(
      .PERIOD(TICK_CYCLES)
   ) u_tick (
      .clk(MCLK),
      .rst_b(RST_B),
      .tick(tick)
   );

   pqc_interval_timer #(
      .WIDTH(CNT_W)
   ) u_quiet (
      .clk(MCLK),
      .rst_b(RST_B),
      .run(quiet_run),
      .tick(quiet_tick),
      .limit(quiet_limit),
      .done(quiet_done)
   );

   pqc_interval_timer #(
      .WIDTH(CNT_W)
   ) u_total (
      .clk(MCLK),
      .rst_b(RST_B),
      .run(total_run),
      .tick(tick),
      .limit(total_limit),
      .done(total_done)
   );

   // ****************************************
   // Read word of the capability register
   // ****************************************
   always_comb begin
      cap_word = '0;
      cap_word[ACK_BIT] = (cur_ff.state == ST_ACKED);
      cap_word[HWCAP_BIT] = HW_QACK_CAP;
      cap_word[FWD_BIT] = FWD_CAP;
      cap_word[LINK_LSB +: LINK_W] = LINK_FIELD;
   end

   // ****************************************
   // Next state
   // ****************************************
   always_comb begin
      nxt_cur = cur_ff;
      events = '0;

      // ****************************************
      // Sequencer
      // ****************************************
      unique case (cur_ff.state)
         ST_IDLE: begin
            if (cur_ff.qreq) begin
               nxt_cur.state = ST_QUIET;
            end
         end
         ST_QUIET: begin
            if (!cur_ff.qreq) begin
               nxt_cur.state = ST_IDLE;
            end else if (HW_QACK_CAP ? HW_QUIESCED : quiet_done) begin
               nxt_cur.state = ST_ACKED;
               events[EV_ACK_SET] = 1'b1;
            end
         end
         ST_ACKED: begin
            if (!cur_ff.qreq) begin
               nxt_cur.state = ST_IDLE;
               events[EV_ACK_CLR] = 1'b1;
            end
         end
         default: begin
            nxt_cur.state = ST_IDLE;
         end
      endcase

      // ****************************************
      // Timeout flag
      // ****************************************
      // Overrun of twice the interval is flagged once per request
      if (cur_ff.state != ST_QUIET) begin
         nxt_cur.timeout_seen = 1'b0;
      end else if (total_done && !cur_ff.timeout_seen && nxt_cur.state == ST_QUIET) begin
         nxt_cur.timeout_seen = 1'b1;
         events[EV_TIMEOUT] = 1'b1;
      end

      // ****************************************
      // Quiet phase
      // ****************************************
      // Restarts whenever the port goes busy, like the idle count itself
      if (!quiet_run) begin
         nxt_cur.phase = '0;
      end else if (cur_ff.phase == TICK_W'(TICK_CYCLES - 1)) begin
         nxt_cur.phase = '0;
      end else begin
         nxt_cur.phase = cur_ff.phase + 1'b1;
      end

      // ****************************************
      // Register writes
      // ****************************************
      if (WR) begin
         unique case (ADDR)
            OFS_PORT_CTRL: begin
               nxt_cur.qreq = WDATA[QREQ_BIT];
            end
            OFS_COMN_CTRL2: begin
               nxt_cur.scale = WDATA[TSCALE_LSB +: TSCALE_W];
               nxt_cur.tvalue = WDATA[TVALUE_LSB +: TVALUE_W];
            end
            OFS_BCAST_LO: begin
               nxt_cur.bcast[31:0] = WDATA & link_present[31:0];
            end
            OFS_BCAST_HI: begin
               nxt_cur.bcast[63:32] = WDATA & link_present[63:32];
            end
            OFS_IRQ_MASK: begin
               nxt_cur.irq_mask = WDATA[EV_W-1:0];
            end
            default: begin
            end
         endcase
      end

      // ****************************************
      // Register reads
      // ****************************************
      // Reads answer one cycle later; unmapped reads give zero
      nxt_cur.rdata = '0;
      if (RD) begin
         unique case (ADDR)
            OFS_CAP_STAT: begin
               nxt_cur.rdata = cap_word;
            end
            OFS_FWD_VEC: begin
               nxt_cur.rdata = FWD_CAP ? {16'h0000, FWD_VECTOR} : '0;
            end
            OFS_PORT_CTRL: begin
               nxt_cur.rdata = DATA_W'(cur_ff.qreq);
            end
            OFS_COMN_CTRL2: begin
               nxt_cur.rdata = DATA_W'({cur_ff.tvalue, 2'h0, cur_ff.scale});
            end
            OFS_BCAST_LO: begin
               nxt_cur.rdata = cur_ff.bcast[31:0];
            end
            OFS_BCAST_HI: begin
               nxt_cur.rdata = cur_ff.bcast[63:32];
            end
            OFS_IRQ_STAT: begin
               nxt_cur.rdata = DATA_W'(cur_ff.irq_stat);
            end
            OFS_IRQ_MASK: begin
               nxt_cur.rdata = DATA_W'(cur_ff.irq_mask);
            end
            default: begin
               nxt_cur.rdata = '0;
            end
         endcase
      end

      // ****************************************
      // Interrupt status
      // ****************************************
      // Read clears status; an event in the same cycle survives the clear
      if (RD && ADDR == OFS_IRQ_STAT) begin
         nxt_cur.irq_stat = events;
      end else begin
         nxt_cur.irq_stat = cur_ff.irq_stat | events;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         cur_ff.state <= ST_IDLE;
         cur_ff.qreq <= 1'b0;
         cur_ff.scale <= TSCALE_RST;
         cur_ff.tvalue <= TVALUE_RST;
         cur_ff.bcast <= '0;
         cur_ff.phase <= '0;
         cur_ff.timeout_seen <= 1'b0;
         cur_ff.irq_stat <= '0;
         cur_ff.irq_mask <= IRQ_MASK_RST;
         cur_ff.rdata <= '0;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign RDATA = cur_ff.rdata;
   assign PORT_QUIESCE_REQUEST = cur_ff.qreq;
   assign PORT_QUIESCE_ACK = (cur_ff.state == ST_ACKED);
   assign BCAST_FWD_VECTOR = cur_ff.bcast;
   assign IRQ = |(cur_ff.irq_stat & cur_ff.irq_mask);

endmodule : pqc_port_status

/* File: verif/pqc_port_monitor.sv */
`timescale 1ns/1ps
module pqc_port_monitor
   import pqc_pkg::*;
#(
   parameter bit HW_QACK_CAP = 1'b0,
   parameter bit FWD_CAP = 1'b0,
   parameter int LINK_COUNT = 1
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic [pqc_pkg::ADDR_W-1:0] ADDR,
   input wire logic [pqc_pkg::DATA_W-1:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [pqc_pkg::DATA_W-1:0] RDATA,
   input wire logic PORT_IDLE,
   input wire logic HW_QUIESCED,
   input wire logic PORT_QUIESCE_REQUEST,
   input wire logic PORT_QUIESCE_ACK,
   input wire logic [pqc_pkg::MAX_LINKS-1:0] BCAST_FWD_VECTOR,
   input wire logic IRQ
);
   // ******
   // Interval tracking, snooped from bus writes
   // ******
   logic [7:0] tv_ff;
   logic [1:0] ts_ff;
   logic [31:0] run_ff;
   logic [31:0] wait_ff;
   logic [31:0] ival;
   logic busy_req;
   assign ival = (32'(tv_ff) << (3 * ts_ff)) * TICK_CYCLES;
   assign busy_req = PORT_IDLE && PORT_QUIESCE_REQUEST;
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         tv_ff <= TVALUE_RST;
         ts_ff <= TSCALE_RST;
         run_ff <= '0;
         wait_ff <= '0;
      end else begin
         if (WR && ADDR == OFS_COMN_CTRL2) begin
            tv_ff <= WDATA[TVALUE_LSB +: TVALUE_W];
            ts_ff <= WDATA[TSCALE_LSB +: TSCALE_W];
         end
         // Idle run restarts on any busy cycle, like the port's own count
         run_ff <= busy_req ? run_ff + 1 : '0;
         wait_ff <= (busy_req && !PORT_QUIESCE_ACK) ? wait_ff + 1 : '0;
      end
   end

   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   sequence s_req_off;
      $fell(PORT_QUIESCE_REQUEST);
   endsequence
   sequence s_cap_rd;
      RD && ADDR == OFS_CAP_STAT;
   endsequence

   a_ack_needs_req: assert property ($rose(PORT_QUIESCE_ACK) |-> PORT_QUIESCE_REQUEST)
      else $error("ack rose without request");
   a_ack_full_idle: assert property (!HW_QACK_CAP && $rose(PORT_QUIESCE_ACK) |-> run_ff >= ival)
      else $error("ack before a full idle interval");
   a_ack_in_time: assert property (wait_ff <= 2 * ival)
      else $error("ack later than twice the interval");
   a_ack_follows_req: assert property (s_req_off |=> !PORT_QUIESCE_ACK)
      else $error("ack stayed after request cleared");
   a_req_from_write: assert property (WR && ADDR == OFS_PORT_CTRL |=>
      PORT_QUIESCE_REQUEST == $past(WDATA[QREQ_BIT]))
      else $error("request bit not written");
   a_cap_fields: assert property (s_cap_rd |=> RDATA[HWCAP_BIT] == HW_QACK_CAP && RDATA[FWD_BIT] == FWD_CAP
      && RDATA[LINK_LSB +: LINK_W] == 6'(LINK_COUNT))
      else $error("capability fields wrong");
   a_ack_bit_read: assert property (s_cap_rd |=> RDATA[ACK_BIT] == $past(PORT_QUIESCE_ACK))
      else $error("ack bit read differs from ack");
   a_link_nonzero: assert property (s_cap_rd |=> RDATA[LINK_LSB +: LINK_W] != 6'h00)
      else $error("link count read as zero");
   a_bcast_links: assert property ((BCAST_FWD_VECTOR >> LINK_COUNT) == '0
      && (FWD_CAP || BCAST_FWD_VECTOR == '0))
      else $error("broadcast vector beyond links");
endmodule : pqc_port_monitor

bind pqc_port_status pqc_port_monitor #(.HW_QACK_CAP(HW_QACK_CAP), .FWD_CAP(FWD_CAP), .LINK_COUNT(LINK_COUNT))
   u_mon (.MCLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .PORT_IDLE, .HW_QUIESCED, .PORT_QUIESCE_REQUEST,
   .PORT_QUIESCE_ACK, .BCAST_FWD_VECTOR, .IRQ);

/* File: verif/pqc_txn_model.sv */
`timescale 1ns/1ps
module pqc_txn_model #(
   parameter int DRAIN = 6
) (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic start,
   input wire logic [3:0] burst,
   input wire logic quiesce_req,
   output logic PORT_IDLE,
   output logic HW_QUIESCED
);
   // ******
   // Outstanding responses, one drained every DRAIN cycles
   // ******
   logic [3:0] out_ff;
   logic [7:0] gap_ff;
   always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
         out_ff <= 4'h0;
         gap_ff <= 8'h00;
      end else if (start && !quiesce_req) begin
         out_ff <= burst;
         gap_ff <= 8'h00;
      end else if (out_ff != 4'h0) begin
         gap_ff <= (gap_ff == 8'(DRAIN - 1)) ? 8'h00 : gap_ff + 8'h01;
         out_ff <= (gap_ff == 8'(DRAIN - 1)) ? out_ff - 4'h1 : out_ff;
      end
   end
   assign PORT_IDLE = (out_ff == 4'h0);
   assign HW_QUIESCED = quiesce_req && PORT_IDLE;
endmodule : pqc_txn_model

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb;
   import pqc_pkg::*;
   // ******
   // Bench
   // ******
   localparam int LINKS = 5;
   localparam logic [15:0] FVEC = 16'h00A5;
   localparam logic [31:0] CAP = 32'((LINKS << LINK_LSB) | (1 << FWD_BIT));
   localparam logic [31:0] CAP_HW = 32'((1 << LINK_LSB) | (1 << HWCAP_BIT));
   logic ack_hw;
   logic [DATA_W-1:0] rdata_hw;
   logic [MAX_LINKS-1:0] bcast_hw;
   logic MCLK, RST_B, WR, RD, start, IRQ;
   logic PORT_IDLE, HW_QUIESCED, PORT_QUIESCE_REQUEST, PORT_QUIESCE_ACK;
   logic [ADDR_W-1:0] ADDR;
   logic [DATA_W-1:0] WDATA, RDATA;
   logic [MAX_LINKS-1:0] BCAST_FWD_VECTOR;
   logic [3:0] burst;
   int fail_count, n_checks, n;

   pqc_port_status #(.HW_QACK_CAP(1'b0), .FWD_CAP(1'b1), .LINK_COUNT(LINKS), .FWD_VECTOR(FVEC)) u_dut (.MCLK,
      .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA, .PORT_IDLE, .HW_QUIESCED, .PORT_QUIESCE_REQUEST, .PORT_QUIESCE_ACK,
      .BCAST_FWD_VECTOR, .IRQ);
   pqc_txn_model u_txn (.MCLK, .RST_B, .start, .burst, .quiesce_req(PORT_QUIESCE_REQUEST), .PORT_IDLE,
      .HW_QUIESCED);
   // Second port takes the hardware path, fed by the same partner
   pqc_port_status #(.HW_QACK_CAP(1'b1)) u_dut_hw (.MCLK, .RST_B, .ADDR, .WDATA, .WR, .RD, .RDATA(rdata_hw),
      .PORT_IDLE, .HW_QUIESCED, .PORT_QUIESCE_REQUEST(), .PORT_QUIESCE_ACK(ack_hw),
      .BCAST_FWD_VECTOR(bcast_hw), .IRQ());

   task automatic print_verdict();
      if (fail_count == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : print_verdict
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge MCLK);
      ADDR <= a;
      WDATA <= d;
      WR <= 1'b1;
      @(posedge MCLK);
      WR <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge MCLK);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge MCLK);
      RD <= 1'b0;
      #1;
      check(64'(RDATA), 64'(exp));
   endtask : rd
   // Bounded wait for idle (sel=1) or ack (sel=0)
   task automatic waitfor(input bit sel, output int c);
      c = 0;
      while ((sel ? PORT_IDLE : PORT_QUIESCE_ACK) !== 1'b1) begin
         @(posedge MCLK);
         #1;
         c++;
         if (c > 300) begin
            fail_count++;
            print_verdict();
         end
      end
   endtask : waitfor

   initial begin
      MCLK = 1'b0;
      forever #50 MCLK = ~MCLK;
   end
   initial begin
      repeat (20000) @(posedge MCLK);
      fail_count++;
      print_verdict();
   end

   initial begin
      RST_B = 1'b0;
      WR = 1'b0;
      RD = 1'b0;
      ADDR = '0;
      WDATA = '0;
      start = 1'b0;
      burst = 4'h0;
      fail_count = 0;
      n_checks = 0;
      repeat (10) @(posedge MCLK);
      RST_B <= 1'b1;
      @(posedge MCLK);
      #1 check({BCAST_FWD_VECTOR != 0, RDATA, IRQ, PORT_QUIESCE_ACK, PORT_QUIESCE_REQUEST}, '0);
      rd(OFS_CAP_STAT, CAP);
      check(rdata_hw, CAP_HW);
      wr(OFS_CAP_STAT, 32'hFFFFFFFF);
      rd(OFS_CAP_STAT, CAP);
      rd(OFS_FWD_VEC, 32'(FVEC));
      check(rdata_hw, 32'h0);
      rd(8'h3C, 32'h0);
      rd(OFS_COMN_CTRL2, 32'(TVALUE_RST) << TVALUE_LSB);
      wr(OFS_COMN_CTRL2, 32'h40);
      rd(OFS_COMN_CTRL2, 32'h40);
      wr(OFS_IRQ_MASK, 32'h7);
      rd(OFS_IRQ_MASK, 32'h7);
      // Idle port: 4 us interval, 40 cycles
      wr(OFS_PORT_CTRL, 32'h1);
      waitfor(1'b0, n);
      check(n >= 40 && n <= 80, 1'b1);
      rd(OFS_CAP_STAT, CAP | 32'h8);
      check(rdata_hw, CAP_HW | 32'h8);
      check(IRQ, 1'b1);
      rd(OFS_IRQ_STAT, 32'h1);
      rd(OFS_IRQ_STAT, 32'h0);
      check(IRQ, 1'b0);
      wr(OFS_IRQ_MASK, 32'h1);
      wr(OFS_PORT_CTRL, 32'h0);
      repeat (2) @(posedge MCLK);
      #1 check({IRQ, PORT_QUIESCE_ACK, ack_hw}, 3'h0);
      rd(OFS_IRQ_STAT, 32'h2);
      // Busy port: idle count held at zero until idle, ack late
      @(posedge MCLK);
      start <= 1'b1;
      burst <= 4'hF;
      @(posedge MCLK);
      start <= 1'b0;
      wr(OFS_PORT_CTRL, 32'h1);
      repeat (82) @(posedge MCLK);
      #1 check(PORT_QUIESCE_ACK, 1'b0);
      check(ack_hw, 1'b0);
      waitfor(1'b1, n);
      waitfor(1'b0, n);
      check(n >= 40, 1'b1);
      check(ack_hw, 1'b1);
      rd(OFS_IRQ_STAT, 32'h5);
      // Request withdrawn before the interval ends
      wr(OFS_PORT_CTRL, 32'h0);
      wr(OFS_PORT_CTRL, 32'h1);
      repeat (5) @(posedge MCLK);
      wr(OFS_PORT_CTRL, 32'h0);
      repeat (80) @(posedge MCLK);
      #1 check(PORT_QUIESCE_ACK, 1'b0);
      rd(OFS_IRQ_STAT, 32'h2);
      wr(OFS_BCAST_LO, 32'hFFFFFFFF);
      wr(OFS_BCAST_HI, 32'hFFFFFFFF);
      rd(OFS_BCAST_LO, 32'h1F);
      rd(OFS_BCAST_HI, 32'h0);
      check(BCAST_FWD_VECTOR, 64'h1F);
      check(bcast_hw, 64'h0);
      print_verdict();
   end
endmodule : tb
